/* File: hw/pmu_buck_out.sv */
`timescale 1ns/10ps
module pmu_buck_out
  import pmu_pkg::*;
(
  input wire logic clk_i,          // system clock
  input wire logic reset_n_i,      // async reset
  input wire logic [5:0] pri_i,    // primary code
  input wire logic [5:0] sec_i,    // secondary code
  input wire logic sel_i,          // voltage select pin
  input wire logic on_i,           // converter enable
  input wire logic off_i,          // master off
  output logic [5:0] code_o,       // code in force
  output logic en_o                // effective enable
);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      code_o <= 6'h00;
    else
      code_o <= sel_i ? sec_i : pri_i; // [R9] [R10]
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      en_o <= 1'b0;
    else
      en_o <= on_i & ~off_i; // [R6] [R11]
  end

endmodule

/* File: hw/pmu_pkg.sv */
package pmu_pkg;

  // register offsets
  localparam logic [7:0] PMU_OFF_SYS_MON = 8'h00;
  localparam logic [7:0] PMU_OFF_MSTR_SCR = 8'h01;
  localparam logic [7:0] PMU_OFF_B1_PRI = 8'h20;
  localparam logic [7:0] PMU_OFF_B1_SEC = 8'h21;
  localparam logic [7:0] PMU_OFF_B1_CTL = 8'h22;
  localparam logic [7:0] PMU_OFF_B2_PRI = 8'h30;
  localparam logic [7:0] PMU_OFF_B2_SEC = 8'h31;

  // values after reset
  localparam logic [7:0] PMU_RST_SYS_MON = 8'h47;
  localparam logic [7:0] PMU_RST_MSTR_SCR = 8'h00;
  localparam logic [5:0] PMU_RST_B1_VOLT = 6'h39;
  localparam logic [7:0] PMU_RST_B1_CTL = 8'h00;
  localparam logic [5:0] PMU_RST_B2_VOLT = 6'h24;

  // field positions, system monitor byte
  localparam int PMU_SYS_TIMEOUT_BIT = 7;
  localparam int PMU_SYS_RESP_BIT = 6;
  localparam int PMU_SYS_UNMASK_BIT = 5;
  localparam int PMU_SYS_LOW_BIT = 4;
  // master off byte
  localparam int PMU_MSTR_OFF_BIT = 5;
  // converter control byte
  localparam int PMU_CTL_ON_BIT = 7;
  localparam int PMU_CTL_PHASE_BIT = 6;
  localparam int PMU_CTL_PWM_BIT = 5;
  localparam int PMU_CTL_DLY_LSB = 2;
  localparam int PMU_CTL_FLT_BIT = 1;
  localparam int PMU_CTL_OK_BIT = 0;

  // reset output time-out
  localparam int PMU_CLK_KHZ = 20_000;
  localparam int PMU_RST_SHORT_MS = 65;
  localparam int PMU_RST_LONG_MS = 260;
  localparam int PMU_RST_SHORT_CYC = PMU_RST_SHORT_MS * PMU_CLK_KHZ;
  localparam int PMU_RST_LONG_CYC = PMU_RST_LONG_MS * PMU_CLK_KHZ;
  localparam int PMU_TMR_W = 23;

  // serial bus
  localparam logic [6:0] PMU_DEV_ADDR = 7'h5b; // arbitrary value
  localparam logic [3:0] PMU_BYTE_BITS = 4'h8;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pmu_wr_t;

  typedef struct packed {
    logic on;
    logic phase;
    logic pwm;
    logic [2:0] delay;
    logic flt_en;
  } pmu_buck_ctl_t;

endpackage

/* File: hw/pmu_regs.sv */
`timescale 1ns/10ps
// What this block does
// [R1] bit 7 picks 65 or 260 ms reset
// [R2] bit 6: interrupt or shutdown on low supply
// [R3] supply interrupt masked by default, one unmasks
// [R4] bit 4 reads live supply-low status
// [R5] bits 3:0 set supply threshold
// [R6] master off stops buck one, two, linear five
// [R7] master off clears on button or charger
// [R8] user_bits_a bits stored, volatile
// [R9] primary code used while select pin low
// [R10] secondary code used while select pin high
// [R11] control bit 7 enables converter
// [R12] control bit 6 sets switching phase
// [R13] control bit 5 forces fixed frequency
// [R14] control bits 4:2 set turn-on delay
// [R15] control bit 1 enables fault interrupts
// [R16] control bit 0 reads power good
// [R17] every bit resets on undervoltage lockout
// [R18] read-only reserved bits read zero
module pmu_regs
  import pmu_pkg::*;
#(
  parameter int RST_SHORT_CYC = PMU_RST_SHORT_CYC,
  parameter int RST_LONG_CYC = PMU_RST_LONG_CYC,
  parameter bit CHARGER_CLEARS_OFF = 1'b0
)
(
  input wire logic clk_i,                 // 20 MHz clock
  input wire logic reset_n_i,             // lockout reset, low
  input wire logic scl_i,                 // serial clock
  input wire logic sda_i,                 // serial data in
  output logic sda_o,                     // serial data out
  output logic sda_oe_o,                  // drive data low
  input wire logic supply_low_i,          // rail below threshold
  input wire logic push_button_n_i,       // push button, low
  input wire logic charger_valid_i,       // charger supply ok
  input wire logic voltage_select_pin_i,  // code select pin
  input wire logic buck_one_ok_i,         // buck one power good
  input wire logic buck_one_fault_i,      // buck one fault
  output logic reset_output_pin_n_o,      // reset out, low
  output logic [3:0] supply_threshold_o,  // detector threshold
  output logic supply_irq_o,              // supply interrupt
  output logic auto_shutdown_o,           // shutdown request
  output logic [5:0] buck_one_code_o,     // buck one code
  output logic buck_one_en_o,             // buck one enable
  output logic buck_one_phase_o,          // 180 degree phase
  output logic buck_one_pwm_o,            // fixed frequency
  output logic [2:0] buck_one_delay_o,    // turn-on delay
  output logic buck_one_fault_irq_o,      // buck one fault irq
  output logic [5:0] buck_two_code_o,     // buck two code
  output logic buck_two_off_o,            // buck two forced off
  output logic linear_five_off_o          // linear five off
);

  typedef enum logic [8:0] {
    PMU_IDLE = 9'h001,
    PMU_ADDR = 9'h002,
    PMU_ADDR_ACK = 9'h004,
    PMU_PTR = 9'h008,
    PMU_PTR_ACK = 9'h010,
    PMU_WDATA = 9'h020,
    PMU_WDATA_ACK = 9'h040,
    PMU_RDATA = 9'h080,
    PMU_RDATA_ACK = 9'h100
  } pmu_state_t;

  pmu_state_t state_q;
  logic scl_q;
  logic sda_q;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic rw_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic drive_low_q;
  pmu_wr_t wr_q;

  // register storage
  logic timeout_short_q;
  logic resp_irq_q;
  logic unmask_q;
  logic [3:0] threshold_q;
  logic [1:0] mstr_rsvd_hi_q;
  logic mstr_rsvd_lo_q;
  logic master_off_q;
  logic [3:0] user_bits_a_q;
  logic [5:0] b1_pri_q;
  logic [5:0] b1_sec_q;
  pmu_buck_ctl_t b1_ctl_q;
  logic [5:0] b2_pri_q;
  logic [5:0] b2_sec_q;
  logic b1_en;
  logic [7:0] rd_now;

  // read decode shared by every byte the host fetches
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      PMU_OFF_SYS_MON:
        v = {timeout_short_q, resp_irq_q, unmask_q, supply_low_i,
             threshold_q}; // [R4]
      PMU_OFF_MSTR_SCR:
        v = {mstr_rsvd_hi_q, master_off_q, mstr_rsvd_lo_q,
             user_bits_a_q};
      PMU_OFF_B1_PRI:
        v = {2'b00, b1_pri_q}; // [R18]
      PMU_OFF_B1_SEC:
        v = {2'b00, b1_sec_q}; // [R18]
      PMU_OFF_B1_CTL:
        v = {b1_ctl_q.on, b1_ctl_q.phase, b1_ctl_q.pwm, b1_ctl_q.delay,
             b1_ctl_q.flt_en, buck_one_ok_i}; // [R16]
      PMU_OFF_B2_PRI:
        v = {2'b00, b2_pri_q}; // [R18]
      PMU_OFF_B2_SEC:
        v = {2'b00, b2_sec_q}; // [R18]
      default:
        v = 8'h00;
    endcase
    return v;
  endfunction

  assign rd_now = read_reg(ptr_q);

  // bus lines are taken as synchronous; one stage kept for edges
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;

  // bit shifter, counts data bits only
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
    end
    else if (start_cond)
      bit_cnt_q <= 4'h0;
    else if (scl_fall && (state_q == PMU_ADDR_ACK ||
             state_q == PMU_PTR_ACK || state_q == PMU_WDATA_ACK ||
             state_q == PMU_RDATA_ACK))
      bit_cnt_q <= 4'h0;
    else if (scl_rise && (state_q == PMU_ADDR || state_q == PMU_PTR ||
             state_q == PMU_WDATA || state_q == PMU_RDATA))
    begin
      shift_q <= {shift_q[6:0], sda_i};
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // protocol sequencer
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= PMU_IDLE;
      rw_q <= 1'b0;
    end
    else if (start_cond)
      state_q <= PMU_ADDR;
    else if (stop_cond)
      state_q <= PMU_IDLE;
    else if (scl_rise && state_q == PMU_RDATA_ACK && sda_i)
      state_q <= PMU_IDLE; // host nack ends the read
    else if (scl_fall)
    begin
      case (state_q)
        PMU_ADDR:
          if (bit_cnt_q == PMU_BYTE_BITS)
          begin
            if (shift_q[7:1] == PMU_DEV_ADDR)
            begin
              state_q <= PMU_ADDR_ACK;
              rw_q <= shift_q[0];
            end
            else
              state_q <= PMU_IDLE;
          end
        PMU_ADDR_ACK:
          state_q <= rw_q ? PMU_RDATA : PMU_PTR;
        PMU_PTR:
          if (bit_cnt_q == PMU_BYTE_BITS)
            state_q <= PMU_PTR_ACK;
        PMU_PTR_ACK:
          state_q <= PMU_WDATA;
        PMU_WDATA:
          if (bit_cnt_q == PMU_BYTE_BITS)
            state_q <= PMU_WDATA_ACK;
        PMU_WDATA_ACK:
          state_q <= PMU_WDATA;
        PMU_RDATA:
          if (bit_cnt_q == PMU_BYTE_BITS)
            state_q <= PMU_RDATA_ACK;
        PMU_RDATA_ACK:
          state_q <= PMU_RDATA;
        PMU_IDLE:
          state_q <= PMU_IDLE;
        default:
          state_q <= PMU_IDLE;
      endcase
    end
  end

  // register pointer, write strobe and read byte
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      wr_q <= '0;
    end
    else
    begin
      wr_q.en <= 1'b0;
      if (scl_fall)
      begin
        if (state_q == PMU_PTR && bit_cnt_q == PMU_BYTE_BITS)
          ptr_q <= shift_q;
        else if (state_q == PMU_WDATA && bit_cnt_q == PMU_BYTE_BITS)
        begin
          wr_q.en <= 1'b1;
          wr_q.addr <= ptr_q;
          wr_q.data <= shift_q;
          ptr_q <= ptr_q + 1'b1;
        end
        else if ((state_q == PMU_ADDR_ACK && rw_q) ||
                 state_q == PMU_RDATA_ACK)
        begin
          // sampled at load so a byte stays stable while shifted out
          tx_q <= rd_now;
          ptr_q <= ptr_q + 1'b1;
        end
      end
    end
  end

  // open-drain data line: only ever pulls low
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      drive_low_q <= 1'b0;
    else if (start_cond || stop_cond)
      drive_low_q <= 1'b0;
    else if (scl_fall)
    begin
      case (state_q)
        PMU_ADDR:
          drive_low_q <= (bit_cnt_q == PMU_BYTE_BITS) &&
                         (shift_q[7:1] == PMU_DEV_ADDR);
        PMU_PTR, PMU_WDATA:
          drive_low_q <= (bit_cnt_q == PMU_BYTE_BITS);
        PMU_ADDR_ACK:
          drive_low_q <= rw_q & ~rd_now[7];
        PMU_RDATA_ACK:
          drive_low_q <= ~rd_now[7];
        PMU_RDATA:
          if (bit_cnt_q == PMU_BYTE_BITS)
            drive_low_q <= 1'b0;
          else
            drive_low_q <= ~tx_q[3'(7 - bit_cnt_q)];
        default:
          drive_low_q <= 1'b0;
      endcase
    end
    else if (state_q == PMU_IDLE)
      drive_low_q <= 1'b0;
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drive_low_q;

  // system monitor byte; lockout reset restores every field
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      timeout_short_q <= PMU_RST_SYS_MON[PMU_SYS_TIMEOUT_BIT]; // [R17]
      resp_irq_q <= PMU_RST_SYS_MON[PMU_SYS_RESP_BIT];
      unmask_q <= PMU_RST_SYS_MON[PMU_SYS_UNMASK_BIT]; // [R3]
      threshold_q <= PMU_RST_SYS_MON[3:0];
    end
    else if (wr_q.en && wr_q.addr == PMU_OFF_SYS_MON)
    begin
      timeout_short_q <= wr_q.data[PMU_SYS_TIMEOUT_BIT]; // [R1]
      resp_irq_q <= wr_q.data[PMU_SYS_RESP_BIT]; // [R2]
      unmask_q <= wr_q.data[PMU_SYS_UNMASK_BIT]; // [R3]
      threshold_q <= wr_q.data[3:0]; // [R5]
    end
  end

  // master off and user_bits_a byte
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mstr_rsvd_hi_q <= PMU_RST_MSTR_SCR[7:6]; // [R17]
      mstr_rsvd_lo_q <= PMU_RST_MSTR_SCR[4];
      user_bits_a_q <= PMU_RST_MSTR_SCR[3:0];
    end
    else if (wr_q.en && wr_q.addr == PMU_OFF_MSTR_SCR)
    begin
      mstr_rsvd_hi_q <= wr_q.data[7:6];
      mstr_rsvd_lo_q <= wr_q.data[4];
      user_bits_a_q <= wr_q.data[3:0]; // [R8]
    end
  end

  // wake events win over a host write landing in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      master_off_q <= PMU_RST_MSTR_SCR[PMU_MSTR_OFF_BIT];
    else if (!push_button_n_i ||
             (CHARGER_CLEARS_OFF && charger_valid_i))
      master_off_q <= 1'b0; // [R7]
    else if (wr_q.en && wr_q.addr == PMU_OFF_MSTR_SCR)
      master_off_q <= wr_q.data[PMU_MSTR_OFF_BIT]; // [R6]
  end

  // buck one voltage codes and control
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      b1_pri_q <= PMU_RST_B1_VOLT;
      b1_sec_q <= PMU_RST_B1_VOLT;
      b1_ctl_q <= pmu_buck_ctl_t'(PMU_RST_B1_CTL[7:1]);
    end
    else if (wr_q.en)
    begin
      if (wr_q.addr == PMU_OFF_B1_PRI)
        b1_pri_q <= wr_q.data[5:0]; // [R9]
      if (wr_q.addr == PMU_OFF_B1_SEC)
        b1_sec_q <= wr_q.data[5:0]; // [R10]
      if (wr_q.addr == PMU_OFF_B1_CTL)
      begin
        b1_ctl_q.on <= wr_q.data[PMU_CTL_ON_BIT]; // [R11]
        b1_ctl_q.phase <= wr_q.data[PMU_CTL_PHASE_BIT]; // [R12]
        b1_ctl_q.pwm <= wr_q.data[PMU_CTL_PWM_BIT]; // [R13]
        b1_ctl_q.delay <= wr_q.data[PMU_CTL_DLY_LSB +: 3]; // [R14]
        b1_ctl_q.flt_en <= wr_q.data[PMU_CTL_FLT_BIT]; // [R15]
      end
    end
  end

  // buck two voltage codes
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      b2_pri_q <= PMU_RST_B2_VOLT;
      b2_sec_q <= PMU_RST_B2_VOLT;
    end
    else if (wr_q.en)
    begin
      if (wr_q.addr == PMU_OFF_B2_PRI)
        b2_pri_q <= wr_q.data[5:0]; // [R9]
      if (wr_q.addr == PMU_OFF_B2_SEC)
        b2_sec_q <= wr_q.data[5:0]; // [R10]
    end
  end

  pmu_buck_out u_buck_one (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pri_i(b1_pri_q),
    .sec_i(b1_sec_q),
    .sel_i(voltage_select_pin_i),
    .on_i(b1_ctl_q.on),
    .off_i(master_off_q),
    .code_o(buck_one_code_o),
    .en_o(b1_en)
  );

  // buck two enable lives elsewhere; only master off is driven here
  pmu_buck_out u_buck_two (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pri_i(b2_pri_q),
    .sec_i(b2_sec_q),
    .sel_i(voltage_select_pin_i),
    .on_i(1'b1),
    .off_i(master_off_q),
    .code_o(buck_two_code_o),
    .en_o()
  );

  assign buck_one_en_o = b1_en;

  // monitor and converter side outputs, all registered
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      supply_irq_o <= 1'b0;
      auto_shutdown_o <= 1'b0;
      buck_one_fault_irq_o <= 1'b0;
      buck_two_off_o <= 1'b0;
      linear_five_off_o <= 1'b0;
    end
    else
    begin
      supply_irq_o <= supply_low_i & resp_irq_q & unmask_q; // [R2] [R3]
      auto_shutdown_o <= supply_low_i & ~resp_irq_q; // [R2]
      buck_one_fault_irq_o <= buck_one_fault_i & b1_ctl_q.flt_en; // [R15]
      buck_two_off_o <= master_off_q; // [R6]
      linear_five_off_o <= master_off_q; // [R6]
    end
  end

  assign supply_threshold_o = threshold_q; // [R5]
  assign buck_one_phase_o = b1_ctl_q.phase; // [R12]
  assign buck_one_pwm_o = b1_ctl_q.pwm; // [R13]
  assign buck_one_delay_o = b1_ctl_q.delay; // [R14]

  // reset output held while the rail is low, then for the time-out
  pmu_rst_timer #(
    .SHORT_CYC(RST_SHORT_CYC),
    .LONG_CYC(RST_LONG_CYC)
  ) u_rst_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(supply_low_i),
    .short_i(timeout_short_q), // [R1]
    .done_o(reset_output_pin_n_o)
  );

endmodule

/* File: hw/pmu_rst_timer.sv */
`timescale 1ns/10ps
module pmu_rst_timer
  import pmu_pkg::*;
#(
  parameter int SHORT_CYC = PMU_RST_SHORT_CYC,
  parameter int LONG_CYC = PMU_RST_LONG_CYC
)
(
  input wire logic clk_i,     // system clock
  input wire logic reset_n_i, // async reset
  input wire logic restart_i, // hold timer at zero
  input wire logic short_i,   // 1: short time-out
  output logic done_o         // time-out elapsed
);

  logic [PMU_TMR_W-1:0] cnt_q;
  logic [PMU_TMR_W-1:0] limit;

  assign limit = short_i ? PMU_TMR_W'(SHORT_CYC - 1) :
                           PMU_TMR_W'(LONG_CYC - 1);

  // select is read live, so a change mid-count takes effect at once
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q <= '0;
      done_o <= 1'b0;
    end
    else if (restart_i)
    begin
      cnt_q <= '0;
      done_o <= 1'b0;
    end
    else if (!done_o)
    begin
      if (cnt_q >= limit)
        done_o <= 1'b1;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

/* File: verification/pmu_host_model.sv */
`timescale 1ns/10ps
module pmu_host_model
  import pmu_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic sda_i, // resolved data line
  output logic scl_o,     // serial clock
  output logic sda_o      // 0 pulls line low
);
  localparam int PH = 4; // above the three cycle phase minimum
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    tick(PH);
    scl_o = 1'b1;
    tick(PH);
    r = sda_i;
    scl_o = 1'b0;
    tick(1);
  endtask
  task automatic start;
    sda_o = 1'b1;
    tick(1);
    scl_o = 1'b1;
    tick(PH);
    sda_o = 1'b0;
    tick(PH);
    scl_o = 1'b0;
    tick(1);
  endtask
  task automatic stop;
    sda_o = 1'b0;
    tick(1);
    scl_o = 1'b1;
    tick(PH);
    sda_o = 1'b1;
    tick(PH);
  endtask
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ack);
    logic a0, a1, a2;
    start();
    byte_out({PMU_DEV_ADDR, 1'b0}, a0);
    byte_out(a, a1);
    byte_out(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ack);
    logic a0, a1, a2, r;
    start();
    byte_out({PMU_DEV_ADDR, 1'b0}, a0);
    byte_out(a, a1);
    start();
    byte_out({PMU_DEV_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule

/* File: verification/pmu_regs_monitor.sv */
`timescale 1ns/10ps
module pmu_regs_monitor
  import pmu_pkg::*;
#(
  parameter int RST_SHORT_CYC = PMU_RST_SHORT_CYC,
  parameter int RST_LONG_CYC = PMU_RST_LONG_CYC
)
(
  input wire logic clk_i,                    // clock
  input wire logic reset_n_i,                // lockout reset
  input wire logic scl_i,                    // serial clock
  input wire logic sda_oe_o,                 // data pull-down
  input wire logic supply_low_i,             // rail low
  input wire logic push_button_n_i,          // button
  input wire logic buck_one_fault_i,         // fault in
  input wire logic reset_output_pin_n_o,     // reset out
  input wire logic [3:0] supply_threshold_o, // threshold
  input wire logic supply_irq_o,             // supply irq
  input wire logic auto_shutdown_o,          // shutdown
  input wire logic [5:0] buck_one_code_o,    // code one
  input wire logic buck_one_en_o,            // enable one
  input wire logic buck_one_fault_irq_o,     // fault irq
  input wire logic [5:0] buck_two_code_o,    // code two
  input wire logic buck_two_off_o,           // off two
  input wire logic linear_five_off_o         // off five
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  int cnt_q;
  // saturates so a long quiet rail cannot wrap the count
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cnt_q <= 0;
    else if (supply_low_i)
      cnt_q <= 0;
    else if (cnt_q < RST_LONG_CYC + 8)
      cnt_q <= cnt_q + 1;
  end
  sequence s_released;
    $rose(reset_n_i);
  endsequence
  sequence s_btn_held;
    (!push_button_n_i) [*4];
  endsequence
  AST_RESET_DEFAULTS: assert property (s_released |=>
    buck_one_code_o == PMU_RST_B1_VOLT && buck_two_code_o == PMU_RST_B2_VOLT
    && supply_threshold_o == PMU_RST_SYS_MON[3:0] && !buck_one_en_o
    && !buck_two_off_o && !supply_irq_o) else $error("defaults wrong");
  AST_OFF_PAIR: assert property (linear_five_off_o == buck_two_off_o)
    else $error("master off outputs differ");
  AST_EN_OFF: assert property (buck_two_off_o |-> !buck_one_en_o)
    else $error("buck one on under master off");
  AST_BTN_CLEAR: assert property (s_btn_held |-> !buck_two_off_o)
    else $error("master off kept under button");
  AST_IRQ_CAUSE: assert property (supply_irq_o |->
    $past(supply_low_i)) else $error("supply irq without low rail");
  AST_SHUT_CAUSE: assert property (auto_shutdown_o |->
    $past(supply_low_i) && !supply_irq_o) else $error("bad shutdown");
  AST_FAULT_CAUSE: assert property (buck_one_fault_irq_o |->
    $past(buck_one_fault_i)) else $error("fault irq without fault");
  AST_RSTO_LOW: assert property (supply_low_i |=>
    !reset_output_pin_n_o) else $error("reset out high on low rail");
  AST_RSTO_MIN: assert property ($rose(reset_output_pin_n_o) |->
    cnt_q >= RST_SHORT_CYC) else $error("reset out too early");
  AST_RSTO_MAX: assert property (cnt_q > RST_LONG_CYC + 3 |->
    reset_output_pin_n_o) else $error("reset out too late");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed with clock high");
endmodule

bind pmu_regs pmu_regs_monitor #(.RST_SHORT_CYC(RST_SHORT_CYC),
  .RST_LONG_CYC(RST_LONG_CYC)) u_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .scl_i(scl_i), .sda_oe_o(sda_oe_o), .supply_low_i(supply_low_i),
  .push_button_n_i(push_button_n_i), .buck_one_fault_i(buck_one_fault_i),
  .reset_output_pin_n_o(reset_output_pin_n_o),
  .supply_threshold_o(supply_threshold_o), .supply_irq_o(supply_irq_o),
  .auto_shutdown_o(auto_shutdown_o), .buck_one_code_o(buck_one_code_o),
  .buck_one_en_o(buck_one_en_o), .buck_one_fault_irq_o(buck_one_fault_irq_o),
  .buck_two_code_o(buck_two_code_o), .buck_two_off_o(buck_two_off_o),
  .linear_five_off_o(linear_five_off_o));

/* File: verification/pmu_regs_tb_top.sv */
`timescale 1ns/10ps
module pmu_regs_tb_top
  import pmu_pkg::*;
();
  localparam int SHORT = 20;
  localparam int LONG = 80;
  logic clk_i = 1'b0;
  logic reset_n = 1'b0;
  logic sup_low = 1'b0;
  logic btn_n = 1'b1;
  logic voltage_select_pin = 1'b0;
  logic ok = 1'b0;
  logic flt = 1'b0;
  logic chg = 1'b0;
  logic scl, host_sda, sda_dut, sda_oe, sda_line, rst_out_n, irq, shut;
  logic en1, ph1, pwm1, firq1, off2, off5;
  logic [3:0] thr;
  logic [2:0] dly1;
  logic [5:0] c1, c2;
  int num_errors = 0;
  int compares = 0;
  always #25 clk_i = ~clk_i;
  assign sda_line = (sda_oe ? sda_dut : 1'b1) & host_sda;
  pmu_host_model host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl),
    .sda_o(host_sda));
  pmu_regs #(.RST_SHORT_CYC(SHORT), .RST_LONG_CYC(LONG),
    .CHARGER_CLEARS_OFF(1'b1)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_dut), .sda_oe_o(sda_oe), .supply_low_i(sup_low),
    .push_button_n_i(btn_n), .charger_valid_i(chg),
    .voltage_select_pin_i(voltage_select_pin), .buck_one_ok_i(ok),
    .buck_one_fault_i(flt), .reset_output_pin_n_o(rst_out_n),
    .supply_threshold_o(thr), .supply_irq_o(irq), .auto_shutdown_o(shut),
    .buck_one_code_o(c1), .buck_one_en_o(en1), .buck_one_phase_o(ph1),
    .buck_one_pwm_o(pwm1), .buck_one_delay_o(dly1),
    .buck_one_fault_irq_o(firq1), .buck_two_code_o(c2),
    .buck_two_off_o(off2), .linear_five_off_o(off5));
  task automatic summarize;
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ack;
    host.wr(a, d, ack);
    chk({7'h00, ack}, 8'h01);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ack;
    host.rd(a, d, ack);
    chk({7'h00, ack}, 8'h01);
    chk(d, exp);
  endtask
  // the timer runs from the rail going good, so count from the caller
  task automatic wait_rst(input int lim);
    int n;
    n = 0;
    while (rst_out_n !== 1'b1 && n < LONG + 20)
    begin
      host.tick(1);
      n++;
    end
    if (n >= LONG + 20)
    begin
      num_errors++;
      summarize();
    end
    chk({7'h00, n >= lim && n <= lim + 3}, 8'h01);
  endtask
  task automatic t_defaults;
    rdc(PMU_OFF_SYS_MON, PMU_RST_SYS_MON);
    rdc(PMU_OFF_MSTR_SCR, PMU_RST_MSTR_SCR);
    rdc(PMU_OFF_B1_PRI, {2'b00, PMU_RST_B1_VOLT});
    rdc(PMU_OFF_B1_SEC, {2'b00, PMU_RST_B1_VOLT});
    rdc(PMU_OFF_B1_CTL, PMU_RST_B1_CTL);
    rdc(PMU_OFF_B2_PRI, {2'b00, PMU_RST_B2_VOLT});
    rdc(PMU_OFF_B2_SEC, {2'b00, PMU_RST_B2_VOLT});
    rdc(8'h23, 8'h00);
  endtask
  task automatic t_volts;
    wr(PMU_OFF_B1_PRI, 8'hff);
    rdc(PMU_OFF_B1_PRI, 8'h3f);
    wr(PMU_OFF_B1_SEC, 8'h15);
    wr(PMU_OFF_B2_PRI, 8'h0a);
    wr(PMU_OFF_B2_SEC, 8'h2b);
    host.tick(2);
    chk({c1, 2'b00}, 8'hfc);
    chk({c2, 2'b00}, 8'h28);
    voltage_select_pin = 1'b1;
    host.tick(3);
    chk({c1, 2'b00}, 8'h54);
    chk({c2, 2'b00}, 8'hac);
    voltage_select_pin = 1'b0;
  endtask
  task automatic t_ctl;
    ok = 1'b1;
    wr(PMU_OFF_B1_CTL, 8'hfe);
    rdc(PMU_OFF_B1_CTL, 8'hff);
    chk({en1, ph1, pwm1, dly1, firq1, 1'b0}, 8'hfc);
    flt = 1'b1;
    host.tick(3);
    chk({7'h00, firq1}, 8'h01);
    ok = 1'b0;
    wr(PMU_OFF_B1_CTL, 8'h14);
    rdc(PMU_OFF_B1_CTL, 8'h14);
    chk({en1, ph1, pwm1, dly1, firq1, 1'b0}, 8'h14);
    flt = 1'b0;
  endtask
  task automatic t_master_off;
    wr(PMU_OFF_B1_CTL, 8'h80);
    wr(PMU_OFF_MSTR_SCR, 8'hea);
    host.tick(2);
    chk({5'h00, en1, off2, off5}, 8'h03);
    rdc(PMU_OFF_MSTR_SCR, 8'hea);
    btn_n = 1'b0;
    host.tick(4);
    btn_n = 1'b1;
    host.tick(2);
    chk({5'h00, en1, off2, off5}, 8'h04);
    rdc(PMU_OFF_MSTR_SCR, 8'hca);
    wr(PMU_OFF_MSTR_SCR, 8'h20);
    chk({6'h00, off2, off5}, 8'h03);
    chg = 1'b1;
    host.tick(2);
    chg = 1'b0;
    chk({6'h00, off2, off5}, 8'h00);
  endtask
  task automatic t_supply;
    wr(PMU_OFF_SYS_MON, 8'he3);
    chk({4'h0, thr}, 8'h03);
    sup_low = 1'b1;
    host.tick(3);
    chk({6'h00, irq, shut}, 8'h02);
    chk({7'h00, rst_out_n}, 8'h00);
    rdc(PMU_OFF_SYS_MON, 8'hf3);
    wr(PMU_OFF_SYS_MON, 8'h29);
    host.tick(2);
    chk({6'h00, irq, shut}, 8'h01);
    wr(PMU_OFF_SYS_MON, 8'h49);
    host.tick(2);
    chk({2'h0, irq, shut, thr}, 8'h09);
    sup_low = 1'b0;
    wait_rst(LONG);
    rdc(PMU_OFF_SYS_MON, 8'h49);
    wr(PMU_OFF_SYS_MON, 8'hc9);
    sup_low = 1'b1;
    host.tick(2);
    sup_low = 1'b0;
    wait_rst(SHORT);
  endtask
  task automatic t_uvlo;
    wr(PMU_OFF_MSTR_SCR, 8'h0f);
    reset_n = 1'b0;
    host.tick(2);
    chk({7'h00, rst_out_n}, 8'h00);
    reset_n = 1'b1;
    host.tick(2);
    rdc(PMU_OFF_MSTR_SCR, 8'h00);
    rdc(PMU_OFF_B2_SEC, {2'b00, PMU_RST_B2_VOLT});
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    #1;
    reset_n = 1'b1;
    wait_rst(LONG);
    t_defaults();
    t_volts();
    t_ctl();
    t_master_off();
    t_supply();
    t_uvlo();
    summarize();
  end
endmodule
